// file: pkg/taod_pkg.sv
/*
  Shared types and constants for the transfer and arithmetic opcode decoder.
  Assumes a byte-wide fetch stream and an execution datapath that consumes
  one decoded instruction record at a time.
*/
package taod_pkg;

  // Operation selects handed to the datapath.
  typedef enum logic [4:0] {
    TAOD_OP_NONE,
    TAOD_OP_TRANSFER_OP,
    TAOD_OP_SEG_LOAD,
    TAOD_OP_SEG_STORE,
    TAOD_OP_TABLE_BYTE_LOOKUP,
    TAOD_OP_POINTER_LOAD_DATA_SEGMENT,
    TAOD_OP_POINTER_LOAD_EXTRA_SEGMENT,
    TAOD_OP_FLAGS_TO_HIGH_BYTE,
    TAOD_OP_HIGH_BYTE_TO_FLAGS,
    TAOD_OP_ADD,
    TAOD_OP_ADD_CARRY,
    TAOD_OP_UNPACKED_BCD_SUM_FIX,
    TAOD_OP_PACKED_BCD_SUM_FIX,
    TAOD_OP_SUBTRACT,
    TAOD_OP_BORROW_DIFFERENCE_OP,
    TAOD_OP_UNPACKED_BCD_DIFFERENCE_FIX,
    TAOD_OP_PACKED_BCD_DIFFERENCE_FIX,
    TAOD_OP_COMPARE_OP,
    TAOD_OP_PRODUCT_UNSIGNED,
    TAOD_OP_PRODUCT_SIGNED,
    TAOD_OP_UNPACKED_BCD_PRODUCT_FIX,
    TAOD_OP_QUOTIENT_UNSIGNED,
    TAOD_OP_QUOTIENT_SIGNED,
    TAOD_OP_UNPACKED_BCD_QUOTIENT_PREP,
    TAOD_OP_BYTE_TO_WORD_EXTEND,
    TAOD_OP_WORD_TO_PAIR_EXTEND
  } taod_op_type;

  // Decoded instruction record, registered at the decoder output.
  typedef struct packed {
    taod_op_type op;
    logic        illegal;
    logic        word;
    logic        to_reg;
    logic        acc_form;
    logic        has_modrm;
    logic [1:0]  mode;
    logic [2:0]  reg_field;
    logic [2:0]  rm_field;
    logic [15:0] disp;
    logic [15:0] imm;
    logic [2:0]  length;
  } taod_dec_type;

  // Single-byte opcodes.
  localparam logic [7:0] TAOD_OPC_SEG_LOAD = 8'h8E;
  localparam logic [7:0] TAOD_OPC_SEG_STORE = 8'h8C;
  localparam logic [7:0] TAOD_OPC_TABLE = 8'hD7;
  localparam logic [7:0] TAOD_OPC_PTR_DATA = 8'hC5;
  localparam logic [7:0] TAOD_OPC_PTR_EXTRA = 8'hC4;
  localparam logic [7:0] TAOD_OPC_FLAGS_OUT = 8'h9F;
  localparam logic [7:0] TAOD_OPC_FLAGS_IN = 8'h9E;
  localparam logic [7:0] TAOD_OPC_UBCD_SUM = 8'h37;
  localparam logic [7:0] TAOD_OPC_PBCD_SUM = 8'h27;
  localparam logic [7:0] TAOD_OPC_UBCD_DIFF = 8'h3F;
  localparam logic [7:0] TAOD_OPC_PBCD_DIFF = 8'h2F;
  localparam logic [7:0] TAOD_OPC_UBCD_PROD = 8'hD4;
  localparam logic [7:0] TAOD_OPC_UBCD_QUOT = 8'hD5;
  localparam logic [7:0] TAOD_OPC_BCD_BASE = 8'h0A;
  localparam logic [7:0] TAOD_OPC_BYTE_EXT = 8'h98;
  localparam logic [7:0] TAOD_OPC_WORD_EXT = 8'h99;

  // Six-bit prefixes of forms with direction (sign for the immediate group) and width bits.
  localparam logic [5:0] TAOD_PFX_TRANSFER = 6'h22;
  localparam logic [5:0] TAOD_PFX_ADD = 6'h00;
  localparam logic [5:0] TAOD_PFX_ADC = 6'h04;
  localparam logic [5:0] TAOD_PFX_SUB = 6'h0A;
  localparam logic [5:0] TAOD_PFX_SBB = 6'h06;
  localparam logic [5:0] TAOD_PFX_IMM_GROUP = 6'h20;

  // Seven-bit prefixes of forms with a width bit only.
  localparam logic [6:0] TAOD_PFX_ADD_ACC = 7'h02;
  localparam logic [6:0] TAOD_PFX_ADC_ACC = 7'h0A;
  localparam logic [6:0] TAOD_PFX_SUB_ACC = 7'h16;
  localparam logic [6:0] TAOD_PFX_UNARY_GROUP = 7'h7B;

  // Sub-operation codes in the middle field of the second byte.
  localparam logic [2:0] TAOD_SUB_ADD = 3'h0;
  localparam logic [2:0] TAOD_SUB_ADC = 3'h2;
  localparam logic [2:0] TAOD_SUB_SBB = 3'h3;
  localparam logic [2:0] TAOD_SUB_SUB = 3'h5;
  localparam logic [2:0] TAOD_SUB_COMPARE = 3'h7;
  localparam logic [2:0] TAOD_SUB_UPROD = 3'h4;
  localparam logic [2:0] TAOD_SUB_SPROD = 3'h5;
  localparam logic [2:0] TAOD_SUB_DIV = 3'h6;
  localparam logic [2:0] TAOD_SUB_SQUOT = 3'h7;

  // Addressing kind codes and the direct-address register/memory code.
  localparam logic [1:0] TAOD_MODE_NO_DISP = 2'h0;
  localparam logic [1:0] TAOD_MODE_DISP8 = 2'h1;
  localparam logic [1:0] TAOD_MODE_DISP16 = 2'h2;
  localparam logic [1:0] TAOD_MODE_REG = 2'h3;
  localparam logic [2:0] TAOD_RM_DIRECT = 3'h6;

  // Longest instruction that this decoder handles, in bytes.
  localparam int TAOD_MAX_LEN = 6;

endpackage

// file: hw/taod_field_split.sv
/*
  Field splitter for the second instruction byte and length planning.
  Purely combinational; assumes the caller already knows whether the
  instruction carries a second addressing byte and how much immediate data.
*/
`timescale 1ns/1ps
module taod_field_split (
  input wire logic [7:0] modrm,
  input wire logic has_modrm,
  input wire logic [1:0] imm_bytes,
  output logic [1:0] mode,
  output logic [2:0] sub_field,
  output logic [2:0] rm_field,
  output logic [1:0] disp_bytes,
  output logic [2:0] length
);

  // The addressing byte holds kind, middle field and register/memory field.
  assign mode = modrm[7:6];
  assign sub_field = modrm[5:3];
  assign rm_field = modrm[2:0];

  // Displacement size follows the addressing kind; direct address is two.
  always_comb
  begin
    disp_bytes = 2'd0;
    if (has_modrm)
    begin
      unique case (mode)
        taod_pkg::TAOD_MODE_NO_DISP:
          disp_bytes = (rm_field == taod_pkg::TAOD_RM_DIRECT) ? 2'd2 : 2'd0;
        taod_pkg::TAOD_MODE_DISP8: disp_bytes = 2'd1;
        taod_pkg::TAOD_MODE_DISP16: disp_bytes = 2'd2;
        taod_pkg::TAOD_MODE_REG: disp_bytes = 2'd0;
      endcase
    end
  end

  // Opcode, optional addressing byte, displacement, then immediate data.
  assign length = 3'd1 + {2'd0, has_modrm} + {1'b0, disp_bytes}
                  + {1'b0, imm_bytes};

endmodule

// file: hw/taod_decoder.sv
/*
  Transfer and arithmetic opcode decoder: takes instruction bytes from the
  fetch queue by valid/ready and emits one registered record per instruction.
  Assumes a byte stays put until taken and that out_ready accepts a record.
*/
`timescale 1ns/1ps
module taod_decoder (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] in_byte,
  input wire logic in_valid,
  output logic in_ready,
  output taod_pkg::taod_dec_type out_dec,
  output logic out_valid,
  input wire logic out_ready
);

  // Byte collection states of one instruction.
  typedef enum logic [2:0] {
    TAOD_ST_OPCODE,
    TAOD_ST_MODRM,
    TAOD_ST_DISP,
    TAOD_ST_IMM,
    TAOD_ST_DONE
  } taod_state_type;

  taod_state_type state_reg, state_next;
  logic [7:0] opc_reg, opc_next;      // Held first byte.
  logic [7:0] modrm_reg, modrm_next;  // Held second byte.
  logic [15:0] disp_reg, disp_next;   // Collected displacement.
  logic [15:0] imm_reg, imm_next;     // Collected immediate data.
  logic [1:0] cnt_reg, cnt_next;      // Bytes taken in current field.
  taod_pkg::taod_dec_type dec_reg, dec_next;
  logic valid_reg, valid_next;
  // Static facts about the held opcode.
  logic has_modrm;
  logic [1:0] imm_bytes;
  logic imm_sext;
  logic [1:0] mode;
  logic [2:0] sub_field, rm_field;
  logic [1:0] disp_bytes;
  logic [2:0] length;
  taod_pkg::taod_op_type op;
  logic illegal, take;

  // Ready in every state but the finish state, whether or not the output is free.
  assign in_ready = (state_reg != TAOD_ST_DONE);
  assign take = in_valid && in_ready;
  assign out_dec = dec_reg;
  assign out_valid = valid_reg;

  // Classify the opcode: addressing byte, immediate size and operation.
  always_comb
  begin
    has_modrm = 1'b0;
    imm_bytes = 2'd0;
    imm_sext = 1'b0;
    op = taod_pkg::TAOD_OP_NONE;
    illegal = 1'b0;
    if (opc_reg[7:2] == taod_pkg::TAOD_PFX_TRANSFER)
    begin
      has_modrm = 1'b1;
      op = taod_pkg::TAOD_OP_TRANSFER_OP;
    end
    else if (opc_reg[7:2] == taod_pkg::TAOD_PFX_ADD)
    begin
      has_modrm = 1'b1;
      op = taod_pkg::TAOD_OP_ADD;
    end
    else if (opc_reg[7:2] == taod_pkg::TAOD_PFX_ADC)
    begin
      has_modrm = 1'b1;
      op = taod_pkg::TAOD_OP_ADD_CARRY;
    end
    else if (opc_reg[7:2] == taod_pkg::TAOD_PFX_SUB)
    begin
      has_modrm = 1'b1;
      op = taod_pkg::TAOD_OP_SUBTRACT;
    end
    else if (opc_reg[7:2] == taod_pkg::TAOD_PFX_SBB)
    begin
      has_modrm = 1'b1;
      op = taod_pkg::TAOD_OP_BORROW_DIFFERENCE_OP;
    end
    else if (opc_reg[7:2] == taod_pkg::TAOD_PFX_IMM_GROUP)
    begin
      // Sign and width pick one or two immediate bytes.
      has_modrm = 1'b1;
      imm_sext = opc_reg[1] && opc_reg[0];
      imm_bytes = (opc_reg[1:0] == 2'b01) ? 2'd2 : 2'd1;
      unique case (sub_field)
        taod_pkg::TAOD_SUB_ADD: op = taod_pkg::TAOD_OP_ADD;
        taod_pkg::TAOD_SUB_ADC: op = taod_pkg::TAOD_OP_ADD_CARRY;
        taod_pkg::TAOD_SUB_SBB:
          op = taod_pkg::TAOD_OP_BORROW_DIFFERENCE_OP;
        taod_pkg::TAOD_SUB_SUB: op = taod_pkg::TAOD_OP_SUBTRACT;
        taod_pkg::TAOD_SUB_COMPARE: op = taod_pkg::TAOD_OP_COMPARE_OP;
        default: illegal = 1'b1; // Logic operations live elsewhere.
      endcase
    end
    else if (opc_reg[7:1] == taod_pkg::TAOD_PFX_ADD_ACC)
    begin
      imm_bytes = opc_reg[0] ? 2'd2 : 2'd1;
      op = taod_pkg::TAOD_OP_ADD;
    end
    else if (opc_reg[7:1] == taod_pkg::TAOD_PFX_ADC_ACC)
    begin
      imm_bytes = opc_reg[0] ? 2'd2 : 2'd1;
      op = taod_pkg::TAOD_OP_ADD_CARRY;
    end
    else if (opc_reg[7:1] == taod_pkg::TAOD_PFX_SUB_ACC)
    begin
      imm_bytes = opc_reg[0] ? 2'd2 : 2'd1;
      op = taod_pkg::TAOD_OP_SUBTRACT;
    end
    else if (opc_reg[7:1] == taod_pkg::TAOD_PFX_UNARY_GROUP)
    begin
      has_modrm = 1'b1;
      unique case (sub_field)
        taod_pkg::TAOD_SUB_UPROD:
          op = taod_pkg::TAOD_OP_PRODUCT_UNSIGNED;
        taod_pkg::TAOD_SUB_SPROD:
          op = taod_pkg::TAOD_OP_PRODUCT_SIGNED;
        taod_pkg::TAOD_SUB_DIV:
          op = taod_pkg::TAOD_OP_QUOTIENT_UNSIGNED;
        taod_pkg::TAOD_SUB_SQUOT:
          op = taod_pkg::TAOD_OP_QUOTIENT_SIGNED;
        default: illegal = 1'b1; // Test, invert and negate not served.
      endcase
    end
    else
    begin
      unique case (opc_reg)
        taod_pkg::TAOD_OPC_SEG_LOAD:
        begin
          has_modrm = 1'b1;
          op = taod_pkg::TAOD_OP_SEG_LOAD;
        end
        taod_pkg::TAOD_OPC_SEG_STORE:
        begin
          has_modrm = 1'b1;
          op = taod_pkg::TAOD_OP_SEG_STORE;
        end
        taod_pkg::TAOD_OPC_TABLE:
          op = taod_pkg::TAOD_OP_TABLE_BYTE_LOOKUP;
        taod_pkg::TAOD_OPC_PTR_DATA:
        begin
          has_modrm = 1'b1;
          op = taod_pkg::TAOD_OP_POINTER_LOAD_DATA_SEGMENT;
        end
        taod_pkg::TAOD_OPC_PTR_EXTRA:
        begin
          has_modrm = 1'b1;
          op = taod_pkg::TAOD_OP_POINTER_LOAD_EXTRA_SEGMENT;
        end
        taod_pkg::TAOD_OPC_FLAGS_OUT:
          op = taod_pkg::TAOD_OP_FLAGS_TO_HIGH_BYTE;
        taod_pkg::TAOD_OPC_FLAGS_IN:
          op = taod_pkg::TAOD_OP_HIGH_BYTE_TO_FLAGS;
        taod_pkg::TAOD_OPC_UBCD_SUM:
          op = taod_pkg::TAOD_OP_UNPACKED_BCD_SUM_FIX;
        taod_pkg::TAOD_OPC_PBCD_SUM:
          op = taod_pkg::TAOD_OP_PACKED_BCD_SUM_FIX;
        taod_pkg::TAOD_OPC_UBCD_DIFF:
          op = taod_pkg::TAOD_OP_UNPACKED_BCD_DIFFERENCE_FIX;
        taod_pkg::TAOD_OPC_PBCD_DIFF:
          op = taod_pkg::TAOD_OP_PACKED_BCD_DIFFERENCE_FIX;
        taod_pkg::TAOD_OPC_UBCD_PROD:
        begin
          // Second byte is a fixed base, taken through the modrm slot.
          has_modrm = 1'b1;
          op = taod_pkg::TAOD_OP_UNPACKED_BCD_PRODUCT_FIX;
        end
        taod_pkg::TAOD_OPC_UBCD_QUOT:
        begin
          has_modrm = 1'b1;
          op = taod_pkg::TAOD_OP_UNPACKED_BCD_QUOTIENT_PREP;
        end
        taod_pkg::TAOD_OPC_BYTE_EXT:
          op = taod_pkg::TAOD_OP_BYTE_TO_WORD_EXTEND;
        taod_pkg::TAOD_OPC_WORD_EXT:
          op = taod_pkg::TAOD_OP_WORD_TO_PAIR_EXTEND;
        default: illegal = 1'b1;
      endcase
    end
  end

  // The two-byte decimal forms must not be split into disp fetches.
  logic fixed_pair;
  assign fixed_pair = (opc_reg == taod_pkg::TAOD_OPC_UBCD_PROD)
                   || (opc_reg == taod_pkg::TAOD_OPC_UBCD_QUOT);
  logic [1:0] disp_need; // Displacement bytes the instruction carries.
  logic [2:0] split_len; // Length as the splitter plans it.
  // The splitter decodes the addressing byte and plans the length.
  taod_field_split u_split (
    .modrm(modrm_reg), .has_modrm(has_modrm), .imm_bytes(imm_bytes),
    .mode(mode), .sub_field(sub_field), .rm_field(rm_field),
    .disp_bytes(disp_bytes), .length(split_len)
  );

  assign disp_need = fixed_pair ? 2'd0 : disp_bytes;
  assign length = fixed_pair ? 3'd2 : split_len;

  // Sequencer and field collection; one byte per handshake accepted in a collecting state.
  always_comb
  begin
    state_next = state_reg;
    opc_next = opc_reg;
    modrm_next = modrm_reg;
    disp_next = disp_reg;
    imm_next = imm_reg;
    cnt_next = cnt_reg;
    dec_next = dec_reg;
    valid_next = valid_reg;
    if (valid_reg && out_ready)
      valid_next = 1'b0;
    unique case (state_reg)
      TAOD_ST_OPCODE:
        if (take)
        begin
          opc_next = in_byte;
          modrm_next = 8'h00;
          disp_next = 16'h0000;
          imm_next = 16'h0000;
          cnt_next = 2'd0;
          state_next = TAOD_ST_MODRM; // Classified next cycle.
        end
      TAOD_ST_MODRM: // Opcode held; an addressing byte may follow.
        if (!has_modrm)
          state_next = (imm_bytes != 2'd0) ? TAOD_ST_IMM : TAOD_ST_DONE;
        else if (take)
        begin
          modrm_next = in_byte;
          state_next = TAOD_ST_DISP;
        end
      TAOD_ST_DISP: // Displacement precedes immediate data.
        if (cnt_reg == disp_need)
        begin
          cnt_next = 2'd0;
          state_next = (imm_bytes != 2'd0) ? TAOD_ST_IMM : TAOD_ST_DONE;
        end
        else if (take)
        begin
          if (cnt_reg == 2'd0) // A lone byte is sign-extended.
            disp_next = {{8{in_byte[7]}}, in_byte};
          else
            disp_next = {in_byte, disp_reg[7:0]};
          cnt_next = cnt_reg + 2'd1;
        end
      TAOD_ST_IMM:
        if (cnt_reg == imm_bytes)
          state_next = TAOD_ST_DONE;
        else if (take)
        begin
          if (cnt_reg == 2'd0) // Sign-width 11 widens the byte.
            imm_next = {{8{imm_sext & in_byte[7]}}, in_byte};
          else
            imm_next = {in_byte, imm_reg[7:0]};
          cnt_next = cnt_reg + 2'd1;
        end
      TAOD_ST_DONE: // Wait until the previous record is accepted.
        if (!valid_reg || out_ready)
        begin
          dec_next.op = op;
          dec_next.illegal = illegal
            || (fixed_pair && modrm_reg != taod_pkg::TAOD_OPC_BCD_BASE);
          dec_next.word = opc_reg[0];
          dec_next.to_reg = opc_reg[1];
          dec_next.acc_form = !has_modrm && (imm_bytes != 2'd0);
          dec_next.has_modrm = has_modrm && !fixed_pair;
          dec_next.mode = mode;
          dec_next.reg_field = sub_field;
          dec_next.rm_field = rm_field;
          dec_next.disp = disp_reg;
          dec_next.imm = imm_reg;
          dec_next.length = length;
          valid_next = 1'b1;
          state_next = TAOD_ST_OPCODE;
        end
    endcase
  end

  // State registers only.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= TAOD_ST_OPCODE;
      opc_reg <= 8'h00;
      modrm_reg <= 8'h00;
      disp_reg <= 16'h0000;
      imm_reg <= 16'h0000;
      cnt_reg <= 2'd0;
      dec_reg <= '0;
      valid_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      opc_reg <= opc_next;
      modrm_reg <= modrm_next;
      disp_reg <= disp_next;
      imm_reg <= imm_next;
      cnt_reg <= cnt_next;
      dec_reg <= dec_next;
      valid_reg <= valid_next;
    end
  end

endmodule

// file: sim/taod_decoder_monitor.sv
/*
  Concurrent checks on the ports of the opcode decoder.
  Assumes one clock domain and a bind onto taod_decoder.
*/
`timescale 1ns/1ps
module taod_decoder_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] in_byte,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire taod_pkg::taod_dec_type out_dec,
  input wire logic out_valid,
  input wire logic out_ready
);
  logic [2:0] dn; // Displacement bytes that the record implies.
  logic md_op; // A valid multiply or divide record is shown.
  logic bcd_op; // A valid two-byte decimal fix record is shown.

  // Helper flags are pure functions of the shown record.
  always_comb
  begin
    dn = 3'h0;
    if (out_dec.mode == 2'h1)
      dn = 3'h1;
    else if (out_dec.mode == 2'h2)
      dn = 3'h2;
    else if (out_dec.mode == 2'h0 && out_dec.rm_field == 3'h6)
      dn = 3'h2;
    md_op = out_valid && out_dec.op inside {
      taod_pkg::TAOD_OP_PRODUCT_UNSIGNED, taod_pkg::TAOD_OP_PRODUCT_SIGNED,
      taod_pkg::TAOD_OP_QUOTIENT_UNSIGNED, taod_pkg::TAOD_OP_QUOTIENT_SIGNED};
    bcd_op = out_valid && out_dec.op inside {
      taod_pkg::TAOD_OP_UNPACKED_BCD_PRODUCT_FIX,
      taod_pkg::TAOD_OP_UNPACKED_BCD_QUOTIENT_PREP};
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // A record waiting on the consumer, and a record being handed over.
  sequence s_held;
    out_valid && !out_ready;
  endsequence
  sequence s_done;
    out_valid && out_ready;
  endsequence

  rec_hold_a: assert property (s_held
    |=> out_valid && $stable(out_dec))
    else $error("record changed while waiting");
  // A finished record blocks bytes until the older one is taken.
  stall_block_a: assert property (s_held && !in_ready
    |=> !in_ready)
    else $error("byte accepted while record waits");
  // Only a finish cycle, where bytes are refused, can refill the output.
  rec_gap_a: assert property (s_done && in_ready |=> !out_valid)
    else $error("record repeated after hand over");
  rise_done_a: assert property ($rose(out_valid)
    |-> !$past(in_ready))
    else $error("record appeared without a finish cycle");
  disp_sext_a: assert property (out_valid && out_dec.has_modrm
    && out_dec.mode == 2'h1 |-> out_dec.disp[15:8] == {8{out_dec.disp[7]}})
    else $error("short displacement not sign extended");
  bcd_len_a: assert property (bcd_op |-> out_dec.length == 3'h2)
    else $error("two-byte decimal fix length wrong");
  md_len_a: assert property (md_op |-> out_dec.length == 3'h2 + dn)
    else $error("multiply or divide length wrong");
  acc_len_a: assert property (out_valid && out_dec.acc_form
    && !out_dec.illegal |-> out_dec.length == (out_dec.word ? 3'h3 : 3'h2))
    else $error("accumulator form length wrong");
endmodule

bind taod_decoder taod_decoder_monitor mon (.clk(clk), .arst_n(arst_n),
  .in_byte(in_byte), .in_valid(in_valid), .in_ready(in_ready),
  .out_dec(out_dec), .out_valid(out_valid), .out_ready(out_ready));

// file: sim/taod_fetch_model.sv
/*
  Fetch queue model that offers instruction bytes to the decoder.
  Assumes the bench pushes whole instructions into q, oldest first.
*/
`timescale 1ns/1ps
module taod_fetch_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_ready,
  output logic [7:0] in_byte,
  output logic in_valid
);
  logic [7:0] q[$]; // Bytes still to offer, in stream order.
  logic slow = 1'b0; // Stretch the idle gaps between bytes.
  int taken = 0; // Bytes that the decoder has consumed.
  int gap; // Idle cycles before the next offer.

  // Four idle cycles let every pass-through state of the decoder go by,
  // so an offered byte never meets a state that lets it slip past.
  // The price is a slower stream; with no gap a byte can slip past the decoder.
  initial
  begin
    in_valid = 1'b0;
    in_byte = 8'h00;
    wait (arst_n === 1'b1);
    forever
    begin
      wait (q.size() != 0);
      gap = slow ? 4 + taken % 3 : 4;
      repeat (gap) @(posedge clk);
      #1;
      in_byte = q[0];
      in_valid = 1'b1;
      do @(posedge clk); while (in_ready !== 1'b1);
      #1;
      // A released line shows the inverse of its last value.
      in_byte = ~q.pop_front();
      in_valid = 1'b0;
      taken++;
    end
  end
endmodule

// file: sim/taod_decoder_tb_top.sv
/*
  Self-checking bench for the opcode decoder with a reference model.
  Assumes the fetch model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module taod_decoder_tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic out_ready = 1'b0;
  logic stall = 1'b0; // Consumer rarely ready while set.
  logic in_ready;
  logic in_valid;
  logic out_valid;
  logic [7:0] in_byte;
  taod_pkg::taod_dec_type out_dec;
  taod_pkg::taod_dec_type exp_q[$]; // Expected records.
  taod_pkg::taod_dec_type msk_q[$]; // Fields each record must match.
  int mismatches = 0;
  int tests_run = 0;
  int pushed = 0; // Bytes handed to the fetch model.
  logic [15:0] rs = 16'h002C; // Stimulus generator state.
  logic [15:0] rr = 16'h002C; // Consumer stall generator state.
  logic [2:0] subs [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h7};
  logic [7:0] forms [39] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8E, 8'h8C,
    8'hD7, 8'hC5, 8'hC4, 8'h9F, 8'h9E, 8'h00, 8'h03, 8'h04, 8'h05, 8'h10,
    8'h13, 8'h14, 8'h15, 8'h80, 8'h81, 8'h82, 8'h83, 8'h37, 8'h27, 8'h28,
    8'h2B, 8'h2C, 8'h2D, 8'h18, 8'h1B, 8'h3F, 8'h2F, 8'hF6, 8'hF7, 8'hD4,
    8'hD5, 8'h98, 8'h99};

  taod_decoder dut (.clk(clk), .arst_n(arst_n), .in_byte(in_byte),
    .in_valid(in_valid), .in_ready(in_ready), .out_dec(out_dec),
    .out_valid(out_valid), .out_ready(out_ready));
  taod_fetch_model fq (.clk(clk), .arst_n(arst_n), .in_ready(in_ready),
    .in_byte(in_byte), .in_valid(in_valid));

  always #25 clk = ~clk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Reference model: works out which bytes exist and the record they
  // must give, then queues both.
  task automatic issue(input logic [7:0] opc, input logic [7:0] mrm,
    input logic [15:0] dv, input logic [15:0] iv);
    taod_pkg::taod_dec_type e;
    taod_pkg::taod_dec_type m;
    int hm;
    int nd;
    int ni;
    logic d45;
    e = '0;
    m = '1;
    nd = 0;
    ni = 0;
    d45 = (opc[7:1] == 7'h6A);
    casez ({opc, mrm[5:3]})
    11'b100010?????: e.op = taod_pkg::TAOD_OP_TRANSFER_OP;
    11'b10001110???: e.op = taod_pkg::TAOD_OP_SEG_LOAD;
    11'b10001100???: e.op = taod_pkg::TAOD_OP_SEG_STORE;
    11'b11010111???: e.op = taod_pkg::TAOD_OP_TABLE_BYTE_LOOKUP;
    11'b11000101???:
      e.op = taod_pkg::TAOD_OP_POINTER_LOAD_DATA_SEGMENT;
    11'b11000100???:
      e.op = taod_pkg::TAOD_OP_POINTER_LOAD_EXTRA_SEGMENT;
    11'b10011111???: e.op = taod_pkg::TAOD_OP_FLAGS_TO_HIGH_BYTE;
    11'b10011110???: e.op = taod_pkg::TAOD_OP_HIGH_BYTE_TO_FLAGS;
    11'b000000?????: e.op = taod_pkg::TAOD_OP_ADD;
    11'b0000010????: e.op = taod_pkg::TAOD_OP_ADD;
    11'b000100?????: e.op = taod_pkg::TAOD_OP_ADD_CARRY;
    11'b0001010????: e.op = taod_pkg::TAOD_OP_ADD_CARRY;
    11'b100000??000: e.op = taod_pkg::TAOD_OP_ADD;
    11'b100000??010: e.op = taod_pkg::TAOD_OP_ADD_CARRY;
    11'b100000??011:
      e.op = taod_pkg::TAOD_OP_BORROW_DIFFERENCE_OP;
    11'b100000??101: e.op = taod_pkg::TAOD_OP_SUBTRACT;
    11'b100000??111: e.op = taod_pkg::TAOD_OP_COMPARE_OP;
    11'b00110111???:
      e.op = taod_pkg::TAOD_OP_UNPACKED_BCD_SUM_FIX;
    11'b00100111???: e.op = taod_pkg::TAOD_OP_PACKED_BCD_SUM_FIX;
    11'b001010?????: e.op = taod_pkg::TAOD_OP_SUBTRACT;
    11'b0010110????: e.op = taod_pkg::TAOD_OP_SUBTRACT;
    11'b000110?????:
      e.op = taod_pkg::TAOD_OP_BORROW_DIFFERENCE_OP;
    11'b00111111???:
      e.op = taod_pkg::TAOD_OP_UNPACKED_BCD_DIFFERENCE_FIX;
    11'b00101111???:
      e.op = taod_pkg::TAOD_OP_PACKED_BCD_DIFFERENCE_FIX;
    11'b1111011?100: e.op = taod_pkg::TAOD_OP_PRODUCT_UNSIGNED;
    11'b1111011?101: e.op = taod_pkg::TAOD_OP_PRODUCT_SIGNED;
    11'b1111011?110: e.op = taod_pkg::TAOD_OP_QUOTIENT_UNSIGNED;
    11'b1111011?111: e.op = taod_pkg::TAOD_OP_QUOTIENT_SIGNED;
    11'b10011000???: e.op = taod_pkg::TAOD_OP_BYTE_TO_WORD_EXTEND;
    11'b10011001???: e.op = taod_pkg::TAOD_OP_WORD_TO_PAIR_EXTEND;
    default: e.illegal = 1'b1;
    endcase
    if (d45)
    begin
      // Only a second byte of 0A makes the pair legal; the first names it.
      e.illegal = (mrm != 8'h0A);
      if (opc[0])
        e.op = taod_pkg::TAOD_OP_UNPACKED_BCD_QUOTIENT_PREP;
      else
        e.op = taod_pkg::TAOD_OP_UNPACKED_BCD_PRODUCT_FIX;
    end
    hm = (opc[7:2] inside {6'h22, 6'h00, 6'h04, 6'h0A, 6'h06, 6'h20}) ||
      (opc inside {8'h8E, 8'h8C, 8'hC5, 8'hC4, 8'hF6, 8'hF7, 8'hD4, 8'hD5});
    e.word = opc[0];
    e.to_reg = opc[1];
    e.acc_form = opc[7:1] inside {7'h02, 7'h0A, 7'h16};
    e.has_modrm = (hm != 0);
    {e.mode, e.reg_field, e.rm_field} = mrm;
    if (hm == 0 || d45)
      {m.mode, m.reg_field, m.rm_field} = 8'h00;
    if (d45)
      m.has_modrm = 1'b0;
    if (e.acc_form)
      ni = 1 + opc[0];
    if (opc[7:2] == 6'h20)
      ni = (opc[1:0] == 2'h1) ? 2 : 1;
    if (hm != 0 && !d45 && mrm[7:6] == 2'h1)
      nd = 1;
    if (hm != 0 && !d45 && (mrm[7:6] == 2'h2 || mrm[7:0] ==? 8'b00???110))
      nd = 2;
    e.disp = nd == 2 ? dv : nd == 1 ? {{8{dv[7]}}, dv[7:0]} : 16'h0000;
    e.imm = ni == 2 ? iv : 16'h0000;
    if (ni == 1)
      e.imm = {{8{opc == 8'h83 && iv[7]}}, iv[7:0]};
    e.length = 3'(1 + hm + nd + ni);
    fq.q.push_back(opc);
    if (hm != 0)
      fq.q.push_back(mrm);
    for (int i = 0; i < nd; i++)
      fq.q.push_back(dv[8 * i +: 8]);
    for (int i = 0; i < ni; i++)
      fq.q.push_back(iv[8 * i +: 8]);
    pushed += 32'(e.length);
    exp_q.push_back(e);
    msk_q.push_back(m);
  endtask

  // Random second byte, displacement and data, kept to accepted codes.
  task automatic pick(input logic [7:0] opc, input int sub);
    logic [7:0] mrm;
    rs = lfsr(rs);
    mrm = rs[7:0];
    rs = lfsr(rs);
    if (opc[7:1] == 7'h7B)
      mrm[5:3] = 3'(sub) | 3'h4;
    if (opc[7:2] == 6'h20)
      mrm[5:3] = subs[sub % 5];
    if (opc[7:1] == 7'h46)
      mrm[5] = 1'b0;
    if (opc[7:1] == 7'h6A)
      mrm = 8'h0A;
    issue(opc, mrm, rs, lfsr(rs));
  endtask

  task automatic drain(input string name);
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 9000)
    begin
      @(posedge clk);
      n++;
    end
    if (exp_q.size() != 0)
    begin
      mismatches++;
      $display("BAD %0t records missing in %s", $time, name);
    end
    $display("Test %s done", name);
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Consumer side: ready most cycles, rarely ready while stalling.
  always @(posedge clk)
  begin
    #1;
    rr = lfsr(rr);
    out_ready = stall ? (rr[2:0] == 3'h0) : (rr[1:0] != 2'h0);
  end

  // Every handed-over record is compared with the model's prediction.
  always @(posedge clk)
  begin
    if (arst_n === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1)
    begin
      tests_run++;
      if (exp_q.size() == 0 ||
        ((out_dec ^ exp_q[0]) & msk_q[0]) !== '0)
      begin
        mismatches++;
        $display("BAD %0t record %h not as predicted", $time, out_dec);
      end
      if (exp_q.size() != 0)
      begin
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    arst_n = 1'b1;
    for (int p = 0; p < 3; p++)
    begin
      fq.slow = (p == 1);
      stall = (p == 2);
      foreach (forms[i])
        pick(forms[i], i);
      drain($sformatf("forms pass %0d", p));
    end
    for (int k = 0; k < 20; k++)
      pick(8'h80 + 8'(k / 5), k);
    for (int k = 0; k < 8; k++)
      pick(8'hF6 + 8'(k / 4), k);
    issue(8'hD5, 8'h07, 16'h0000, 16'h0000);
    issue(8'hD4, 8'h0A, 16'h0000, 16'h0000);
    // Sub-operations and opcodes outside the served set decode illegal.
    issue(8'h81, 8'h08, 16'h1234, 16'hBEEF);
    issue(8'hF6, 8'h18, 16'h0000, 16'h0000);
    issue(8'h90, 8'h00, 16'h0000, 16'h0000);
    drain("groups");
    tests_run++;
    if (fq.taken != pushed)
    begin
      mismatches++;
      $display("BAD %0t consumed byte count differs", $time);
    end
    wrap_up();
  end
endmodule
